// file: common/flash_host_pkg.sv
// Constants shared by the page flash host controller and its pin cycle engine.
package flash_host_pkg;
  // APB register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // Control register fields.
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_BYTE_BIT = 8;
  localparam int CTRL_KEEP_BIT = 9;
  // Status register fields.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_DEV_BUSY_BIT = 2;
  localparam int ST_ERASING_BIT = 3;
  localparam int ST_SUSPENDED_BIT = 4;
  localparam int ST_STATUS_MODE_BIT = 5;
  localparam int ST_LOADING_BIT = 6;
  // Reset values.
  localparam logic [21:0] ADDR_RESET = 22'h000000;
  localparam logic [15:0] WDATA_RESET = 16'h0000;
  // Host operations.
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_LOAD = 4'h1, OP_RESET = 4'h2, OP_PROGRAM = 4'h3,
    OP_CHIP_ERASE = 4'h4, OP_SECTOR_ERASE = 4'h5, OP_SUSPEND = 4'h6,
    OP_RESUME = 4'h7, OP_READ_STATUS = 4'h8, OP_ABORT = 4'h9
  } op_t;
  // Device command codes and unlock addresses.
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_ABORT = 8'hE0;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
  localparam int READY_BIT = 7;
  localparam int PAGE_FAST_WORDS = 7;
  localparam int PAGE_FAST_BYTES = 15;
  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_ACC_NS = 120;
  localparam int T_PAGE_NS = 50;
  localparam int T_WP_NS = 100;
  localparam int T_LOAD_GAP_NS = 30000;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;
  localparam int LOAD_GAP_CYC = T_LOAD_GAP_NS / CLK_PERIOD_NS;
  // The strobe gap also spans the done handshake and the next start, about seven cycles.
  localparam int LOAD_MARGIN_CYC = 8;
  localparam int LOAD_CLOSE_CYC = LOAD_GAP_CYC - LOAD_MARGIN_CYC;
endpackage

// file: design/flash_bus_cycle.sv
// Pin cycle engine: one read or write cycle on the flash pins.
`timescale 1ns/1ps
module flash_bus_cycle (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // Request from and reply to the sequencer.
  input wire logic start_i,
  input wire logic write_i,
  input wire logic keep_i,
  input wire logic fast_i,
  input wire logic byte_i,
  input wire logic [20:0] addr_i,
  input wire logic a_m1_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Flash pins.
  output logic [20:0] addr_o,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_SETUP = 2'b01, E_STROBE = 2'b10, E_SYNC = 2'b11} eng_st_t;
  typedef struct packed {
    eng_st_t st;
    logic wr;
    logic keep;
    logic byte_m;
    logic [2:0] cnt;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
    logic [15:0] rdata;
    logic done;
    logic [15:0] s1;
    logic [15:0] s2;
  } eng_t;
  eng_t r;
  eng_t n;
  logic [15:0] idle_oe;

  ////////////////////////////////////////////////////////////////////////////
  // In byte mode the top data pin carries the lowest address bit, so it stays driven.
  assign idle_oe = r.byte_m ? 16'h8000 : 16'h0000;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.s1 = dq_i;
    n.s2 = r.s1;
    case (r.st)
      E_IDLE: begin
        if (start_i) begin
          n.wr = write_i;
          n.keep = keep_i;
          n.byte_m = byte_i;
          n.addr = addr_i;
          n.dq_o = {byte_i ? a_m1_i : wdata_i[15], wdata_i[14:0]};
          n.dq_oe = byte_i ? 16'h8000 : 16'h0000;
          n.ce_n = 1'b0;
          n.oe_n = write_i;
          n.cnt = write_i ? 3'(flash_host_pkg::WP_CYC) :
            (fast_i ? 3'(flash_host_pkg::PAGE_CYC) : 3'(flash_host_pkg::ACC_CYC));
          n.st = write_i ? E_SETUP : E_STROBE;
        end
      end
      E_SETUP: begin
        n.we_n = 1'b0;
        n.dq_oe = r.byte_m ? 16'h80FF : 16'hFFFF;
        n.st = E_STROBE;
      end
      E_STROBE: begin
        if (r.cnt > 3'h1) begin
          n.cnt = r.cnt - 3'h1;
        end else begin
          n.we_n = 1'b1;
          n.cnt = 3'(flash_host_pkg::SYNC_CYC);
          n.st = E_SYNC;
        end
      end
      default: begin
        if (r.cnt > 3'h1) begin
          n.cnt = r.cnt - 3'h1;
        end else begin
          n.done = 1'b1;
          n.st = E_IDLE;
          n.dq_oe = idle_oe;
          if (!r.wr) begin
            n.rdata = r.byte_m ? {8'h00, r.s2[7:0]} : r.s2;
          end
          if (r.wr || !r.keep) begin
            n.ce_n = 1'b1;
            n.oe_n = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '{st: E_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else if (en_i) begin
      r <= n;
    end
  end

  assign done_o = r.done;
  assign rdata_o = r.rdata;
  assign addr_o = r.addr;
  assign dq_o = r.dq_o;
  assign dq_oe_o = r.dq_oe;
  assign ce_n_o = r.ce_n;
  assign oe_n_o = r.oe_n;
  assign we_n_o = r.we_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_load_strobe_shape: assert property (!r.we_n |-> !r.ce_n && r.oe_n)
    else $error("write strobe low without chip select or with output drive");
  chk_data_hold_rise: assert property ($rose(r.we_n) |-> r.dq_oe[0] && $stable(r.dq_o))
    else $error("write data released at strobe rise");
  chk_read_no_drive: assert property (!r.oe_n |-> r.dq_oe[14:0] == 15'h0000)
    else $error("host drives data while flash outputs are on");
  chk_addr_hold_load: assert property (!r.we_n |-> $stable(r.addr))
    else $error("address moved during write strobe");
endmodule

// file: design/flash_host_ctrl.sv
// Host controller that drives a parallel page flash from APB register commands.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - Never send read/reset while flash busy; the code still allows reads then, as status polls, and refuses only reset.
// - Page reads fast within same A3-A20.
// - Program needs two unlocks then A0H.
// - Load pulses strobe; address, data held.
// - Next load within 30us of last.
// - Page address valid on every load.
// - Chip erase is six writes ending 10H.
// - Sector erase ends with 30H at sector.
// - Every sequence opens with two unlocks.
module flash_host_ctrl (
  // Clock, reset and enable.
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Flash pins.
  output logic [20:0] FL_ADDR_O,
  input wire logic [15:0] FL_DQ_I,
  output logic [15:0] FL_DQ_O,
  output logic [15:0] FL_DQ_OE_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O,
  output logic FL_BYTE_N_O
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b10} seq_st_t;
  typedef struct packed {
    seq_st_t st;
    flash_host_pkg::op_t op;
    logic [2:0] step;
    logic byte_m;
    logic keep;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic err;
    logic dev_busy;
    logic erasing;
    logic suspended;
    logic status_mode;
    logic loading;
    logic [9:0] gap_cnt;
    logic page_open;
    logic [17:0] page_tag;
    logic [3:0] fast_cnt;
    logic [31:0] prdata;
    logic slverr;
  } ctl_t;
  ctl_t r;
  ctl_t n;
  logic apb_wr;
  logic go_req;
  flash_host_pkg::op_t req_op;
  logic bus_start;
  logic bus_done;
  logic fast_sel;
  logic [20:0] bus_addr;
  logic [15:0] bus_data;
  logic [15:0] bus_rdata;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] seq_len(input flash_host_pkg::op_t op);
    case (op)
      flash_host_pkg::OP_READ, flash_host_pkg::OP_LOAD: seq_len = 3'd1;
      flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd3;
    endcase
  endfunction

  // Only the sixth write of a sector erase and data cycles carry a real address.
  function automatic logic [20:0] step_addr(input flash_host_pkg::op_t op, input logic [2:0] step,
                                           input logic [21:0] addr);
    if (op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_LOAD) begin
      step_addr = addr[21:1];
    end else if (step == 3'd1 || step == 3'd4) begin
      step_addr = {6'h00, flash_host_pkg::UNLOCK_ADDR2};
    end else if (step == 3'd5 && op == flash_host_pkg::OP_SECTOR_ERASE) begin
      step_addr = {addr[21:17], 16'h0000};
    end else begin
      step_addr = {6'h00, flash_host_pkg::UNLOCK_ADDR1};
    end
  endfunction

  function automatic logic [7:0] op_code(input flash_host_pkg::op_t op);
    case (op)
      flash_host_pkg::OP_PROGRAM: op_code = flash_host_pkg::CMD_PROGRAM;
      flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE: op_code = flash_host_pkg::CMD_SETUP;
      flash_host_pkg::OP_SUSPEND: op_code = flash_host_pkg::CMD_SUSPEND;
      flash_host_pkg::OP_RESUME: op_code = flash_host_pkg::CMD_RESUME;
      flash_host_pkg::OP_READ_STATUS: op_code = flash_host_pkg::CMD_READ_STATUS;
      flash_host_pkg::OP_ABORT: op_code = flash_host_pkg::CMD_ABORT;
      default: op_code = flash_host_pkg::CMD_RESET;
    endcase
  endfunction

  function automatic logic [15:0] step_data(input flash_host_pkg::op_t op, input logic [2:0] step,
                                           input logic [15:0] wdata);
    if (op == flash_host_pkg::OP_LOAD) begin
      step_data = wdata;
    end else begin
      case (step)
        3'd0, 3'd3: step_data = {8'h00, flash_host_pkg::CMD_UNLOCK1};
        3'd1, 3'd4: step_data = {8'h00, flash_host_pkg::CMD_UNLOCK2};
        3'd2: step_data = {8'h00, op_code(op)};
        default: step_data = {8'h00, op == flash_host_pkg::OP_CHIP_ERASE ?
          flash_host_pkg::CMD_CHIP : flash_host_pkg::CMD_SECTOR};
      endcase
    end
  endfunction

  // Host-side mirror of what the flash accepts in each condition.
  function automatic logic op_allowed(input flash_host_pkg::op_t op, input ctl_t s);
    if (s.suspended) begin
      op_allowed = op inside {flash_host_pkg::OP_READ, flash_host_pkg::OP_RESET,
        flash_host_pkg::OP_READ_STATUS, flash_host_pkg::OP_ABORT, flash_host_pkg::OP_RESUME};
    end else if (s.loading) begin
      op_allowed = op == flash_host_pkg::OP_LOAD;
    end else if (s.dev_busy) begin
      op_allowed = op inside {flash_host_pkg::OP_READ, flash_host_pkg::OP_READ_STATUS} ||
        (op == flash_host_pkg::OP_SUSPEND && s.erasing);
    end else begin
      op_allowed = !(op inside {flash_host_pkg::OP_LOAD, flash_host_pkg::OP_SUSPEND,
        flash_host_pkg::OP_RESUME});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && CLK_EN_I;
  assign go_req = apb_wr && PADDR_I == flash_host_pkg::OFS_CTRL && PWDATA_I[flash_host_pkg::CTRL_GO_BIT];
  assign req_op = flash_host_pkg::op_t'(PWDATA_I[flash_host_pkg::CTRL_OP_LSB +: 4]);
  assign bus_addr = step_addr(r.op, r.step, r.addr);
  assign bus_data = step_data(r.op, r.step, r.wdata);
  assign fast_sel = r.page_open && r.addr[21:4] == r.page_tag &&
    r.fast_cnt < (r.byte_m ? 4'(flash_host_pkg::PAGE_FAST_BYTES) : 4'(flash_host_pkg::PAGE_FAST_WORDS));

  always_comb begin
    n = r;
    bus_start = 1'b0;
    if (PSEL_I && !PENABLE_I) begin
      n.slverr = 1'b0;
      case (PADDR_I)
        flash_host_pkg::OFS_CTRL: n.prdata = {22'h0, r.keep, r.byte_m, 3'h0, r.op, 1'b0};
        flash_host_pkg::OFS_ADDR: n.prdata = {10'h0, r.addr};
        flash_host_pkg::OFS_WDATA: n.prdata = {16'h0, r.wdata};
        flash_host_pkg::OFS_RDATA: n.prdata = {16'h0, r.rdata};
        flash_host_pkg::OFS_STATUS: n.prdata = {25'h0, r.loading, r.status_mode, r.suspended,
          r.erasing, r.dev_busy, r.err, r.st != S_IDLE};
        default: begin
          n.prdata = 32'h0000_0000;
          n.slverr = 1'b1;
        end
      endcase
    end
    if (apb_wr && !r.slverr) begin
      case (PADDR_I)
        flash_host_pkg::OFS_CTRL: begin
          // Width may only change between operations so a sequence never mixes widths.
          if (r.st == S_IDLE && !r.loading) begin
            n.byte_m = PWDATA_I[flash_host_pkg::CTRL_BYTE_BIT];
          end
          n.keep = PWDATA_I[flash_host_pkg::CTRL_KEEP_BIT];
        end
        flash_host_pkg::OFS_ADDR: n.addr = PWDATA_I[21:0];
        flash_host_pkg::OFS_WDATA: n.wdata = PWDATA_I[15:0];
        flash_host_pkg::OFS_STATUS: begin
          if (PWDATA_I[flash_host_pkg::ST_ERR_BIT]) begin
            n.err = 1'b0;
          end
        end
        default: n.err = r.err;
      endcase
    end
    case (r.st)
      S_IDLE: begin
        if (r.loading) begin
          if (r.gap_cnt == 10'(flash_host_pkg::LOAD_CLOSE_CYC)) begin
            n.loading = 1'b0;
            n.dev_busy = 1'b1;
          end else begin
            n.gap_cnt = r.gap_cnt + 10'h001;
          end
        end
        if (go_req) begin
          // Judge against the next state so a load never lands in the cycle that closes the window.
          if (op_allowed(req_op, n)) begin
            n.op = req_op;
            n.step = 3'd0;
            n.st = S_ISSUE;
          end else begin
            n.err = 1'b1;
          end
        end
      end
      S_ISSUE: begin
        bus_start = 1'b1;
        n.st = S_WAIT;
        if (r.op == flash_host_pkg::OP_READ) begin
          n.fast_cnt = fast_sel ? r.fast_cnt + 4'h1 : 4'h0;
          n.page_tag = r.addr[21:4];
        end
      end
      default: begin
        if (bus_done) begin
          n.page_open = r.op == flash_host_pkg::OP_READ && r.keep;
          if (r.step + 3'd1 < seq_len(r.op)) begin
            n.step = r.step + 3'd1;
            n.st = S_ISSUE;
          end else begin
            n.st = S_IDLE;
            case (r.op)
              flash_host_pkg::OP_READ: begin
                n.rdata = bus_rdata;
                if (r.status_mode && bus_rdata[flash_host_pkg::READY_BIT]) begin
                  n.dev_busy = 1'b0;
                  n.erasing = r.suspended && r.erasing;
                end
              end
              flash_host_pkg::OP_LOAD: n.gap_cnt = 10'h000;
              flash_host_pkg::OP_PROGRAM: begin
                n.loading = 1'b1;
                n.gap_cnt = 10'h000;
                n.status_mode = 1'b1;
              end
              flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE: begin
                n.dev_busy = 1'b1;
                n.erasing = 1'b1;
                n.status_mode = 1'b1;
              end
              flash_host_pkg::OP_SUSPEND: begin
                n.suspended = 1'b1;
                n.status_mode = 1'b1;
              end
              flash_host_pkg::OP_RESUME: begin
                n.suspended = 1'b0;
                n.dev_busy = 1'b1;
                n.status_mode = 1'b1;
              end
              flash_host_pkg::OP_READ_STATUS: n.status_mode = 1'b1;
              flash_host_pkg::OP_ABORT: begin
                n.suspended = 1'b0;
                n.erasing = 1'b0;
                n.dev_busy = 1'b0;
                n.status_mode = 1'b0;
              end
              default: n.status_mode = 1'b0;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      r <= '{st: S_IDLE, op: flash_host_pkg::OP_READ, addr: flash_host_pkg::ADDR_RESET,
        wdata: flash_host_pkg::WDATA_RESET, default: '0};
    end else if (CLK_EN_I) begin
      r <= n;
    end
  end

  assign PRDATA_O = r.prdata;
  assign PREADY_O = CLK_EN_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && r.slverr;
  assign FL_BYTE_N_O = !r.byte_m;

  ////////////////////////////////////////////////////////////////////////////
  flash_bus_cycle u_cycle (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .en_i(CLK_EN_I),
    .start_i(bus_start),
    .write_i(r.op != flash_host_pkg::OP_READ),
    .keep_i(r.keep),
    .fast_i(fast_sel),
    .byte_i(r.byte_m),
    .addr_i(bus_addr),
    .a_m1_i(r.addr[0]),
    .wdata_i(bus_data),
    .done_o(bus_done),
    .rdata_o(bus_rdata),
    .addr_o(FL_ADDR_O),
    .dq_i(FL_DQ_I),
    .dq_o(FL_DQ_O),
    .dq_oe_o(FL_DQ_OE_O),
    .ce_n_o(FL_CE_N_O),
    .oe_n_o(FL_OE_N_O),
    .we_n_o(FL_WE_N_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  chk_reset_busy_refused: assert property (go_req && req_op == flash_host_pkg::OP_RESET && r.st == S_IDLE
    && r.dev_busy && !r.suspended |=> r.err && r.st == S_IDLE) else $error("reset sent while busy");
  chk_suspend_needs_erase: assert property (go_req && req_op == flash_host_pkg::OP_SUSPEND
    && r.st == S_IDLE && !r.erasing |=> r.err && r.st == S_IDLE) else $error("suspend sent outside erase");
  chk_first_unlock_pair: assert property (bus_start && r.step == 3'd1 && seq_len(r.op) > 3'd1
    |-> bus_addr[14:0] == 15'h2AAA && bus_data[7:0] == 8'h55 && $past(bus_data[7:0], 2) == 8'hAA)
    else $error("unlock pair wrong");
  chk_program_code: assert property (bus_start && r.op == flash_host_pkg::OP_PROGRAM && r.step == 3'd2
    |-> bus_data[7:0] == 8'hA0 && bus_addr[14:0] == 15'h5555) else $error("program code wrong");
  chk_sector_select: assert property (bus_start && r.op == flash_host_pkg::OP_SECTOR_ERASE && r.step == 3'd5
    |-> bus_addr == {r.addr[21:17], 16'h0000} && bus_data[7:0] == 8'h30) else $error("sector address wrong");
  chk_load_window_close: assert property (r.loading && r.st == S_IDLE && CLK_EN_I
    && r.gap_cnt == 10'(flash_host_pkg::LOAD_CLOSE_CYC) |=> !r.loading && r.dev_busy) else $error("load window not closed");
  chk_power_up_array: assert property ($rose(RST_N_I) |-> !r.status_mode && !r.dev_busy)
    else $error("not in array mode after reset");
  chk_ready_clears_busy: assert property (r.st == S_WAIT && bus_done && CLK_EN_I && r.op == flash_host_pkg::OP_READ
    && r.status_mode && bus_rdata[7] |=> !r.dev_busy) else $error("ready not seen");
  chk_fast_page_limit: assert property (bus_start && fast_sel |-> !FL_CE_N_O && !FL_OE_N_O
    && FL_ADDR_O[20:3] == r.addr[21:4] && r.fast_cnt < (r.byte_m ? 4'd15 : 4'd7))
    else $error("fast page read out of page");
endmodule

// file: tb/flash_dev_model.sv
// Behavioural page flash that answers the host controller's pin cycles.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int OP_US = 40
) (
  // Flash pins as seen by the device.
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [int];
  logic [15:0] page [int];
  logic [20:0] la;
  logic [15:0] last = 16'h0000;
  int step = 0;
  int left = 0;
  int idle = 0;
  int sec = 0;
  bit load, ers, susp;
  bit stat = 1'b0;
  wire ready = (left == 0 || susp) && !load;
  always @(negedge we_n_i) if (!ce_n_i) la = addr_i;
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (load) begin
      page[la] = dq_i;
      idle = 0;
    end else if (step % 3 != 2) begin
      step = (la[14:0] == (step % 3 ? 15'h2AAA : 15'h5555) &&
        dq_i[7:0] == (step % 3 ? 8'h55 : 8'hAA)) ? step + 1 : 0;
    end else if (step == 5) begin
      step = 0;
      if (left == 0 && !susp && dq_i[7:0] inside {8'h10, 8'h30}) begin
        sec = dq_i[5] ? int'(la[20:16]) : 32;
        ers = 1'b1;
        left = OP_US;
        stat = 1'b1;
      end
    end else begin
      step = 0;
      case (dq_i[7:0])
        8'hA0: if (left == 0 && !susp) begin
          load = 1'b1;
          stat = 1'b1;
          idle = 0;
          page.delete();
        end
        8'h80: if (!susp) step = 3;
        8'hF0: if (left == 0 || susp) stat = 1'b0;
        8'hB0: if (ers && left > 0) susp = 1'b1;
        8'hD0: susp = 1'b0;
        8'h70: stat = 1'b1;
        8'hE0: begin
          stat = 1'b0;
          left = 0;
          susp = 1'b0;
          load = 1'b0;
        end
        default: stat = stat;
      endcase
    end
  end
  // Time runs in 1 us ticks; the erase clock stops while suspended.
  always begin
    #1000;
    if (load && ++idle >= 100) begin
      load = 1'b0;
      left = OP_US;
    end else if (left > 0 && !susp && --left == 0) begin
      if (!ers) foreach (page[a]) mem[a] = page[a];
      foreach (mem[a]) if (ers && (sec == 32 || a[20:16] == sec)) mem[a] = 16'hFFFF;
      ers = 1'b0;
    end
  end
  always @(addr_i or ce_n_i or oe_n_i or we_n_i or stat or ready) begin
    if (!ce_n_i && !oe_n_i && we_n_i) begin
      dq_o = stat ? {8'h00, ready, susp, 6'h00} : (mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF);
      last = dq_o;
    end else begin
      dq_o = ~last;
    end
  end
endmodule

// file: tb/flash_host_ctrl_bench.sv
// Self-checking bench for the page flash host controller.
`timescale 1ns/1ps
`define CHK(w, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s expected %h seen %h", w, e, g); end end
module flash_host_ctrl_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, st;
  logic pready, pslverr, slverr, ce_n, oe_n, we_n, byte_n;
  logic [20:0] fa;
  logic [15:0] fdi, fdo, doe;
  int fails = 0;
  int samples_checked = 0;
  initial forever #25 clk = ~clk;
  flash_host_ctrl dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FL_ADDR_O(fa), .FL_DQ_I(fdi), .FL_DQ_O(fdo), .FL_DQ_OE_O(doe), .FL_CE_N_O(ce_n),
    .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n), .FL_BYTE_N_O(byte_n));
  // Undriven data bits reach the flash as zero, so a missing output enable corrupts the write.
  flash_dev_model flash (.addr_i(fa), .dq_i(fdo & doe), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(fdi));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic status();
    apb(1'b0, flash_host_pkg::OFS_STATUS, 32'h0);
    st = rd;
  endtask
  task automatic op(input flash_host_pkg::op_t c, input logic [21:0] a, input logic [15:0] d,
                    input logic k = 1'b0);
    apb(1'b1, flash_host_pkg::OFS_ADDR, {10'h000, a});
    apb(1'b1, flash_host_pkg::OFS_WDATA, {16'h0000, d});
    apb(1'b1, flash_host_pkg::OFS_CTRL, {22'h000000, k, 4'h0, c, 1'b1});
    for (int n = 0; n < 400; n++) begin
      status();
      if (st[flash_host_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
    `CHK("op finished", 1'b0, st[flash_host_pkg::ST_BUSY_BIT])
  endtask
  task automatic rdw(input logic [20:0] w, input logic k = 1'b0);
    op(flash_host_pkg::OP_READ, {w, 1'b0}, 16'h0000, k);
    apb(1'b0, flash_host_pkg::OFS_RDATA, 32'h0);
  endtask
  // Polling by status-mode reads is what lets the controller see the ready flag.
  task automatic wait_dev();
    for (int n = 0; n < 400; n++) begin
      status();
      if (st[flash_host_pkg::ST_LOADING_BIT] === 1'b1) repeat (20) @(posedge clk);
      else if (st[flash_host_pkg::ST_DEV_BUSY_BIT] === 1'b1) op(flash_host_pkg::OP_READ, 22'h0, 16'h0);
      else break;
    end
    `CHK("device ready", 1'b0, st[flash_host_pkg::ST_LOADING_BIT] | st[flash_host_pkg::ST_DEV_BUSY_BIT])
  endtask
  task automatic t_refusals();
    rdw(21'h000100);
    `CHK("power-up word", 32'h0000FFFF, rd)
    `CHK("word width pin", 1'b1, byte_n)
    op(flash_host_pkg::OP_LOAD, 22'h000200, 16'h0000);
    status();
    `CHK("stray load refused", 1'b1, st[flash_host_pkg::ST_ERR_BIT])
    apb(1'b1, flash_host_pkg::OFS_STATUS, 32'h00000002);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped error", 1'b1, slverr)
  endtask
  task automatic t_program();
    op(flash_host_pkg::OP_PROGRAM, 22'h0, 16'h0);
    op(flash_host_pkg::OP_LOAD, 22'h000204, 16'h1234);
    op(flash_host_pkg::OP_LOAD, 22'h000200, 16'hA55A);
    status();
    `CHK("loading flag", 1'b1, st[flash_host_pkg::ST_LOADING_BIT])
    wait_dev();
    op(flash_host_pkg::OP_RESET, 22'h0, 16'h0);
    rdw(21'h000100);
    `CHK("loaded word", 32'h0000A55A, rd)
    rdw(21'h000102);
    `CHK("second word", 32'h00001234, rd)
    rdw(21'h000101);
    `CHK("unloaded word", 32'h0000FFFF, rd)
    rdw(21'h000100, 1'b1);
    `CHK("page open word", 32'h0000A55A, rd)
    rdw(21'h000102, 1'b1);
    `CHK("page fast word", 32'h00001234, rd)
  endtask
  task automatic t_erase();
    op(flash_host_pkg::OP_SECTOR_ERASE, 22'h020000, 16'h0);
    status();
    `CHK("erasing flag", 1'b1, st[flash_host_pkg::ST_ERASING_BIT])
    op(flash_host_pkg::OP_RESET, 22'h0, 16'h0);
    status();
    `CHK("reset while busy", 1'b1, st[flash_host_pkg::ST_ERR_BIT])
    apb(1'b1, flash_host_pkg::OFS_STATUS, 32'h00000002);
    wait_dev();
    op(flash_host_pkg::OP_RESET, 22'h0, 16'h0);
    rdw(21'h000100);
    `CHK("other sector kept", 32'h0000A55A, rd)
    op(flash_host_pkg::OP_SECTOR_ERASE, 22'h000000, 16'h0);
    op(flash_host_pkg::OP_SUSPEND, 22'h0, 16'h0);
    status();
    `CHK("suspended flag", 1'b1, st[flash_host_pkg::ST_SUSPENDED_BIT])
    op(flash_host_pkg::OP_PROGRAM, 22'h0, 16'h0);
    status();
    `CHK("program while suspended", 1'b1, st[flash_host_pkg::ST_ERR_BIT])
    apb(1'b1, flash_host_pkg::OFS_STATUS, 32'h00000002);
    op(flash_host_pkg::OP_RESUME, 22'h0, 16'h0);
    wait_dev();
    op(flash_host_pkg::OP_RESET, 22'h0, 16'h0);
    rdw(21'h000100);
    `CHK("erased word", 32'h0000FFFF, rd)
  endtask
  task automatic t_chip();
    op(flash_host_pkg::OP_CHIP_ERASE, 22'h0, 16'h0);
    `CHK("chip erasing", 1'b1, st[flash_host_pkg::ST_ERASING_BIT])
    op(flash_host_pkg::OP_READ_STATUS, 22'h0, 16'h0);
    `CHK("status cmd taken", 1'b0, st[flash_host_pkg::ST_ERR_BIT])
    wait_dev();
    op(flash_host_pkg::OP_ABORT, 22'h0, 16'h0);
    `CHK("array mode", 1'b0, st[flash_host_pkg::ST_STATUS_MODE_BIT])
    rdw(21'h1F0000);
    `CHK("chip erased word", 32'h0000FFFF, rd)
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_refusals();
    t_program();
    t_erase();
    t_chip();
    complete_run();
  end
endmodule
